/* File: shared/boot_handoff_consts.svh */
`ifndef BOOT_HANDOFF_CONSTS_SVH
`define BOOT_HANDOFF_CONSTS_SVH

// shared flash layout, byte wide
`define FLASH_AW            20
`define CFG_BASE            20'hF0000
`define CFG_WORDS           4
`define CFG_LAST            2'h3
`define FW_BASE             20'h00000
`define FW_LAST             4'hF

// host-side target addresses, one per port
`define ADDR_PORT_A         7'h38
`define ADDR_PORT_B         7'h3F

// bit positions in configuration byte 0
`define CFG_SOC_CTRL_BIT    0
`define CFG_EC_GATE_BIT     1
`define CFG_SINK_5A_BIT     2

// fixed power object: 2'b00, 10 spare, voltage in 50 mV, current in 10 mA
`define SRC_V_50MV          10'h064
`define SRC_I_10MA          10'h096
`define SINK_V0_50MV        10'h064
`define SINK_V1_50MV        10'h0B4
`define SINK_V2_50MV        10'h12C
`define SINK_V3_50MV        10'h190
`define SINK_I_10MA         10'h12C
`define SINK_I_MAX_10MA     10'h1F4
`define PDO_COUNT           4

// companion release delay after its supply is good
`define CLK_FREQ_MHZ        40
`define RELEASE_WAIT_US     100
`define RELEASE_WAIT_CYC    (`RELEASE_WAIT_US * `CLK_FREQ_MHZ)
`define WAIT_CNT_W          12

`endif

/* File: shared/boot_handoff_pkg.sv */
package boot_handoff_pkg;

	typedef logic [31:0] pdo_t;
	typedef logic [7:0]  status_t;

	typedef enum logic [1:0] {
		DEV_LOAD_REQ,
		DEV_LOAD_WAIT,
		DEV_RUN
	} dev_state_t;

	typedef enum logic [2:0] {
		CMP_RESET,
		CMP_FETCH_REQ,
		CMP_FETCH_WAIT,
		CMP_IDLE,
		CMP_ASK,
		CMP_WAIT_ANS
	} cmp_state_t;

endpackage

/* File: shared/boot_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface boot_link_if;
	logic       companion_reset_n;
	logic       host_int;
	logic       q_valid;
	logic [6:0] q_addr;
	logic       a_valid;
	logic       a_ack;
	logic [7:0] a_data;

	modport device (
		output companion_reset_n,
		output host_int,
		input  q_valid,
		input  q_addr,
		output a_valid,
		output a_ack,
		output a_data
	);

	modport companion (
		input  companion_reset_n,
		input  host_int,
		output q_valid,
		output q_addr,
		input  a_valid,
		input  a_ack,
		input  a_data
	);
endinterface

`default_nettype wire

/* File: hw/boot_handoff_device.sv */
// Operation
// - load own configuration before companion touches flash
// - companion held in reset during load
// - output zero drives only companion reset
// - companion released 100 us after supply
// - reset gated with companion supply good
// - embedded controller may delay companion release
// - answer both target addresses on host port
// - first address port A, second port B
// - one interrupt feeds both companion inputs
// - companion reads both addresses on interrupt
// - connected port status readable over host port
// - each party reads its own flash region
// - one source object: 5 V, 1.5 A
// - four sink objects, 3 A, 5 A top
// - outputs steer sideband mux aux or link
// - controller-side port drives system-on-chip control
// - embedded controller addresses host-side target port
`include "boot_handoff_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_handoff_device
	import boot_handoff_pkg::*;
(
	input  wire logic                   clock_i,
	input  wire logic                   nrst_i,
	input  wire logic                   ce_i,
	boot_link_if.device                 link,
	output var  logic                   flash_req_o,
	output var  logic [`FLASH_AW-1:0]   flash_addr_o,
	input  wire logic                   flash_ack_i,
	input  wire logic [7:0]             flash_data_i,
	input  wire logic                   attach_a_pin_i,
	input  wire logic                   attach_b_pin_i,
	input  wire logic [6:0]             data_status_a_i,
	input  wire logic [6:0]             data_status_b_i,
	input  wire logic                   dp_mode_i,
	input  wire logic                   ec_boot_done_i,
	output var  logic                   config_done_o,
	output var  logic                   soc_ctrl_en_o,
	output var  logic                   sbu_aux_sel_o,
	output var  logic                   sbu_en_o,
	output var  pdo_t                   src_pdo_o,
	output var  pdo_t [`PDO_COUNT-1:0]  sink_pdo_o
);

	dev_state_t                  state;
	logic [1:0]                  load_idx;
	logic [7:0]                  cfg_mem [`CFG_WORDS];
	logic [1:0]                  attach_pin;
	logic [1:0]                  attach_sync;
	logic [1:0]                  attach_prev;
	logic                        read_a;
	logic                        read_b;
	logic                        int_pend;
	logic                        reset_n_q;

	wire logic                   running;
	wire logic                   load_last;
	wire logic                   hit_a;
	wire logic                   hit_b;
	wire logic                   attach_event;
	wire logic                   both_read;
	wire logic                   next_int_pend;
	wire logic                   next_read_a;
	wire logic                   next_read_b;
	wire logic                   ec_gate;
	wire logic                   next_reset_n;
	wire status_t                status_a;
	wire status_t                status_b;
	wire status_t                next_a_data;
	wire logic [`FLASH_AW-1:0]   next_flash_addr;
	wire logic [9:0]             sink_volt [`PDO_COUNT];
	wire pdo_t [`PDO_COUNT-1:0]  next_sink_pdo;

	assign attach_pin = {attach_b_pin_i, attach_a_pin_i};

	// attach pins come from outside the clock domain
	generate
		for (genvar i = 0; i < 2; i++) begin : g_sync
			logic meta;
			logic stab;
			always_ff @(posedge clock_i or negedge nrst_i) begin
				if (!nrst_i) begin
					meta <= 1'b0;
					stab <= 1'b0;
				end else if (ce_i) begin
					meta <= attach_pin[i];
					stab <= meta;
				end
			end
			assign attach_sync[i] = stab;
		end
	endgenerate

	assign running   = (state == DEV_RUN);
	assign load_last = (load_idx == `CFG_LAST);
	assign next_flash_addr = `CFG_BASE + {{(`FLASH_AW-2){1'b0}}, load_idx};

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state        <= DEV_LOAD_REQ;
			load_idx     <= 2'h0;
			flash_req_o  <= 1'b0;
			flash_addr_o <= `CFG_BASE;
		end else if (ce_i) begin
			case (state)
				DEV_LOAD_REQ: begin
					flash_req_o  <= 1'b1;
					flash_addr_o <= next_flash_addr;
					state        <= DEV_LOAD_WAIT;
				end
				DEV_LOAD_WAIT: begin
					if (flash_ack_i) begin
						flash_req_o <= 1'b0;
						if (load_last) begin
							state <= DEV_RUN;
						end else begin
							load_idx <= load_idx + 2'h1;
							state    <= DEV_LOAD_REQ;
						end
					end
				end
				default: begin
					flash_req_o <= 1'b0;
				end
			endcase
		end
	end

	// configuration bytes land in flops by index
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int k = 0; k < `CFG_WORDS; k++) begin
				cfg_mem[k] <= 8'h00;
			end
		end else if (ce_i && state == DEV_LOAD_WAIT && flash_ack_i) begin
			cfg_mem[load_idx] <= flash_data_i;
		end
	end

	// optional hold until the system has booted
	assign ec_gate = !cfg_mem[0][`CFG_EC_GATE_BIT] || ec_boot_done_i;
	assign next_reset_n = running && ec_gate;

	// reset held low through the whole load
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reset_n_q <= 1'b0;
		end else if (ce_i) begin
			reset_n_q <= next_reset_n;
		end
	end

	// output zero is the companion reset and nothing else
	assign link.companion_reset_n = reset_n_q;

	assign hit_a = link.q_valid && (link.q_addr == `ADDR_PORT_A);
	assign hit_b = link.q_valid && (link.q_addr == `ADDR_PORT_B);

	// live connection and data status per port
	assign status_a    = {attach_sync[0], data_status_a_i};
	assign status_b    = {attach_sync[1], data_status_b_i};
	assign next_a_data = hit_a ? status_a : (hit_b ? status_b : 8'h00);

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			link.a_valid <= 1'b0;
			link.a_ack   <= 1'b0;
			link.a_data  <= 8'h00;
		end else if (ce_i) begin
			link.a_valid <= link.q_valid;
			link.a_ack   <= hit_a || hit_b;
			link.a_data  <= next_a_data;
		end
	end

	// interrupt stays up until both ports were read; a new event wins
	assign attach_event  = |(attach_sync ^ attach_prev);
	assign both_read     = (read_a || hit_a) && (read_b || hit_b);
	// cleared only once both addresses are read
	assign next_int_pend = attach_event || (int_pend && !both_read);
	assign next_read_a   = next_int_pend && !attach_event && (read_a || hit_a) && !both_read;
	assign next_read_b   = next_int_pend && !attach_event && (read_b || hit_b) && !both_read;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			attach_prev <= 2'b00;
			int_pend    <= 1'b0;
			read_a      <= 1'b0;
			read_b      <= 1'b0;
		end else if (ce_i) begin
			attach_prev <= attach_sync;
			int_pend    <= next_int_pend;
			read_a      <= next_read_a;
			read_b      <= next_read_b;
		end
	end

	assign link.host_int = int_pend;

	// sink table, top entry may carry 5 A
	assign sink_volt[0] = `SINK_V0_50MV;
	assign sink_volt[1] = `SINK_V1_50MV;
	assign sink_volt[2] = `SINK_V2_50MV;
	assign sink_volt[3] = `SINK_V3_50MV;

	generate
		for (genvar p = 0; p < `PDO_COUNT; p++) begin : g_sink
			wire logic use_max;
			assign use_max = (p == `PDO_COUNT - 1) && cfg_mem[0][`CFG_SINK_5A_BIT];
			assign next_sink_pdo[p] = {12'h000, sink_volt[p],
				use_max ? `SINK_I_MAX_10MA : `SINK_I_10MA};
		end
	endgenerate

	// power objects fixed at reset; 5 A only after the config says so
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// single 5 V 1.5 A source object
			src_pdo_o  <= {12'h000, `SRC_V_50MV, `SRC_I_10MA};
			sink_pdo_o <= {
				{12'h000, `SINK_V3_50MV, `SINK_I_10MA},
				{12'h000, `SINK_V2_50MV, `SINK_I_10MA},
				{12'h000, `SINK_V1_50MV, `SINK_I_10MA},
				{12'h000, `SINK_V0_50MV, `SINK_I_10MA}};
		end else if (ce_i) begin
			src_pdo_o  <= {12'h000, `SRC_V_50MV, `SRC_I_10MA};
			sink_pdo_o <= next_sink_pdo;
		end
	end

	// mux enable and controller port only act once configured; aux select follows display mode at all times
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			config_done_o <= 1'b0;
			soc_ctrl_en_o <= 1'b0;
			sbu_aux_sel_o <= 1'b0;
			sbu_en_o      <= 1'b0;
		end else if (ce_i) begin
			config_done_o <= running;
			soc_ctrl_en_o <= running && cfg_mem[0][`CFG_SOC_CTRL_BIT];
			// aux when display mode, else link sideband
			sbu_aux_sel_o <= dp_mode_i;
			sbu_en_o      <= running && (|attach_sync);
		end
	end

endmodule

`default_nettype wire

/* File: hw/boot_handoff_companion.sv */
`include "boot_handoff_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_handoff_companion
	import boot_handoff_pkg::*;
(
	input  wire logic                  clock_i,
	input  wire logic                  nrst_i,
	input  wire logic                  ce_i,
	boot_link_if.companion             link,
	input  wire logic                  supply_good_pin_i,
	output var  logic                  flash_req_o,
	output var  logic [`FLASH_AW-1:0]  flash_addr_o,
	input  wire logic                  flash_ack_i,
	input  wire logic [7:0]            flash_data_i,
	output var  logic                  fw_ready_o,
	output var  logic [7:0]            fw_sum_o,
	output var  status_t               port_a_status_o,
	output var  status_t               port_b_status_o
);

	cmp_state_t               state;
	logic                     supply_meta;
	logic                     supply_sync;
	logic [`WAIT_CNT_W-1:0]   wait_cnt;
	logic [3:0]               fetch_idx;
	logic                     ask_b;

	wire logic                wait_done;
	wire logic                released;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			supply_meta <= 1'b0;
			supply_sync <= 1'b0;
		end else if (ce_i) begin
			supply_meta <= supply_good_pin_i;
			supply_sync <= supply_meta;
		end
	end

	// count from supply good before honouring release
	assign wait_done = (wait_cnt == `WAIT_CNT_W'(`RELEASE_WAIT_CYC));

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_cnt <= '0;
		end else if (ce_i) begin
			if (!supply_sync) begin
				wait_cnt <= '0;
			end else if (!wait_done) begin
				wait_cnt <= wait_cnt + `WAIT_CNT_W'(1);
			end
		end
	end

	// reset gated with the supply, covers dead battery
	assign released = link.companion_reset_n && supply_sync && wait_done;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state           <= CMP_RESET;
			fetch_idx       <= 4'h0;
			ask_b           <= 1'b0;
			flash_req_o     <= 1'b0;
			flash_addr_o    <= `FW_BASE;
			fw_ready_o      <= 1'b0;
			fw_sum_o        <= 8'h00;
			link.q_valid    <= 1'b0;
			link.q_addr     <= `ADDR_PORT_A;
			port_a_status_o <= 8'h00;
			port_b_status_o <= 8'h00;
		end else if (ce_i) begin
			link.q_valid <= 1'b0;
			if (!released) begin
				state       <= CMP_RESET;
				fetch_idx   <= 4'h0;
				flash_req_o <= 1'b0;
				fw_ready_o  <= 1'b0;
				fw_sum_o    <= 8'h00;
			end else begin
				case (state)
					CMP_RESET: begin
						state <= CMP_FETCH_REQ;
					end
					CMP_FETCH_REQ: begin
						flash_req_o  <= 1'b1;
						flash_addr_o <= `FW_BASE + {16'h0000, fetch_idx};
						state        <= CMP_FETCH_WAIT;
					end
					CMP_FETCH_WAIT: begin
						if (flash_ack_i) begin
							flash_req_o <= 1'b0;
							fw_sum_o    <= fw_sum_o + flash_data_i;
							fetch_idx   <= fetch_idx + 4'h1;
							state       <= (fetch_idx == `FW_LAST) ? CMP_IDLE : CMP_FETCH_REQ;
						end
					end
					CMP_IDLE: begin
						fw_ready_o <= 1'b1;
						// interrupt triggers a poll of both ports
						if (link.host_int) begin
							ask_b <= 1'b0;
							state <= CMP_ASK;
						end
					end
					CMP_ASK: begin
						link.q_valid <= 1'b1;
						link.q_addr  <= ask_b ? `ADDR_PORT_B : `ADDR_PORT_A;
						state        <= CMP_WAIT_ANS;
					end
					default: begin
						if (link.a_valid) begin
							if (ask_b) begin
								port_b_status_o <= link.a_ack ? link.a_data : 8'h00;
								state           <= CMP_IDLE;
							end else begin
								port_a_status_o <= link.a_ack ? link.a_data : 8'h00;
								ask_b           <= 1'b1;
								state           <= CMP_ASK;
							end
						end
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: test/boot_link_sva.sv */
`include "boot_handoff_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_link_sva (
	input wire logic       clock_i,
	input wire logic       nrst_i,
	input wire logic       companion_reset_n,
	input wire logic       host_int,
	input wire logic       q_valid,
	input wire logic [6:0] q_addr,
	input wire logic       a_valid,
	input wire logic       a_ack,
	input wire logic [7:0] a_data
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	AST_ANS_NEXT: assert property (q_valid |=> a_valid) else $error("query not answered");
	AST_ANS_ONLY: assert property (!q_valid |=> !a_valid) else $error("answer without query");
	AST_ACK_PORTS: assert property (q_valid && (q_addr == `ADDR_PORT_A || q_addr == `ADDR_PORT_B)
		|=> a_ack) else $error("port address refused");
	// answer fields are cleared between answers, so nothing stale can be taken
	AST_ANS_HOLD: assert property (!a_valid |-> !a_ack && (a_data == 8'h00))
		else $error("answer outside its cycle");
	AST_TARGET_ONLY: assert property (a_valid |-> $past(q_valid)) else $error("target spoke unasked");
	AST_INT_CLEAR: assert property ($fell(host_int) |-> a_valid && a_ack) else $error("interrupt lost");
	AST_Q_PULSE: assert property (q_valid |=> !q_valid) else $error("query not one cycle");
	AST_HELD_QUIET: assert property (!companion_reset_n |-> !q_valid) else $error("query in reset");
	AST_RELEASE_KEEPS: assert property (companion_reset_n |=> companion_reset_n)
		else $error("companion reset fell");
endmodule

`default_nettype wire

/* File: test/tb.sv */
`include "boot_handoff_consts.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb
	import boot_handoff_pkg::*;
;
	logic                   clock_i = 1'b0;
	logic                   nrst_i = 1'b0;
	logic                   ce_i = 1'b1;
	logic                   dev_req, cmp_req, cfg_done, soc_en, aux_sel, sbu_en, fw_ready;
	logic                   dev_ack = 1'b0, cmp_ack = 1'b0, att_a = 1'b0, att_b = 1'b0;
	logic                   dp = 1'b0, ec_done = 1'b0, sup = 1'b0;
	logic [`FLASH_AW-1:0]   dev_addr, cmp_addr;
	logic [7:0]             dev_data = 8'h00, cmp_data = 8'h00, cfg = 8'h00, fw_sum;
	logic [6:0]             st_a = 7'h00, st_b = 7'h00;
	logic [9:0]             volt_tab [4] = '{`SINK_V0_50MV, `SINK_V1_50MV, `SINK_V2_50MV, `SINK_V3_50MV};
	pdo_t                   src_pdo;
	pdo_t [`PDO_COUNT-1:0]  sink_pdo;
	status_t                pa, pb;
	int                     miscompares = 0, num_checks = 0, cyc = 0, sup_cyc = 0, first_cmp = 0;

	boot_link_if link ();
	boot_handoff_device i_boot_handoff_device (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .link(link),
		.flash_req_o(dev_req), .flash_addr_o(dev_addr), .flash_ack_i(dev_ack), .flash_data_i(dev_data),
		.attach_a_pin_i(att_a), .attach_b_pin_i(att_b), .data_status_a_i(st_a), .data_status_b_i(st_b),
		.dp_mode_i(dp), .ec_boot_done_i(ec_done), .config_done_o(cfg_done), .soc_ctrl_en_o(soc_en),
		.sbu_aux_sel_o(aux_sel), .sbu_en_o(sbu_en), .src_pdo_o(src_pdo), .sink_pdo_o(sink_pdo));
	boot_handoff_companion i_boot_handoff_companion (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.link(link), .supply_good_pin_i(sup), .flash_req_o(cmp_req), .flash_addr_o(cmp_addr),
		.flash_ack_i(cmp_ack), .flash_data_i(cmp_data), .fw_ready_o(fw_ready), .fw_sum_o(fw_sum),
		.port_a_status_o(pa), .port_b_status_o(pb));
	boot_link_sva i_boot_link_sva (.clock_i(clock_i), .nrst_i(nrst_i), .companion_reset_n(link.companion_reset_n),
		.host_int(link.host_int), .q_valid(link.q_valid), .q_addr(link.q_addr), .a_valid(link.a_valid),
		.a_ack(link.a_ack), .a_data(link.a_data));

	always #12.5 clock_i = ~clock_i;

	// config byte 0 comes from cfg so each boot can pick its options
	function automatic logic [7:0] fbyte(input logic [`FLASH_AW-1:0] a);
		return (a[19:16] == 4'hF) ? ((a[1:0] == 2'h0) ? cfg : 8'h5A) : {4'h3, a[3:0]};
	endfunction

	// shared flash: each requester gets a one-cycle ack per byte
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		dev_ack <= dev_req && !dev_ack;
		cmp_ack <= cmp_req && !cmp_ack;
		dev_data <= fbyte(dev_addr);
		cmp_data <= fbyte(cmp_addr);
		if (cmp_req && first_cmp == 0)
			first_cmp <= cyc;
		if (dev_req)
			`CHK(dev_addr[19:2], 18'h3C000)
		if (cmp_req)
			`CHK({cfg_done, cmp_addr[19:4]}, 17'h10000)
	end

	task automatic chk_pdo(input logic big);
		`CHK(src_pdo, {12'h000, `SRC_V_50MV, `SRC_I_10MA})
		for (int k = 0; k < `PDO_COUNT; k++)
			`CHK(sink_pdo[k], {12'h000, volt_tab[k], (big && k == 3) ? `SINK_I_MAX_10MA : `SINK_I_10MA})
	endtask

	task automatic t_boot;
		repeat (100) begin
			@(negedge clock_i);
			if (cfg_done !== 1'b1)
				`CHK(link.companion_reset_n, 1'b0)
		end
		`CHK(link.companion_reset_n, cfg_done)
		`CHK(link.companion_reset_n, 1'b1)
		`CHK(soc_en, 1'b0)
		chk_pdo(1'b0);
		$display("test boot done");
	endtask

	task automatic t_fetch;
		logic [7:0] s = 8'h00;
		for (int k = 0; k < 16; k++)
			s += 8'h30 + 8'(k);
		// reset already released but supply still down: companion must stay off the flash
		`CHK(first_cmp, 0)
		@(posedge clock_i);
		sup <= 1'b1;
		sup_cyc = cyc;
		repeat (6000) if (fw_ready !== 1'b1) @(negedge clock_i);
		`CHK(fw_ready, 1'b1)
		`CHK(fw_sum, s)
		// supply needs its settling time before the companion may act
		`CHK(first_cmp - sup_cyc >= `RELEASE_WAIT_CYC, 1'b1)
		$display("test fetch done");
	endtask

	task automatic wait_int;
		repeat (20) if (link.host_int !== 1'b1) @(negedge clock_i);
		`CHK(link.host_int, 1'b1)
		repeat (100) if (link.host_int !== 1'b0) @(negedge clock_i);
		`CHK(link.host_int, 1'b0)
		// the last answer is stored one edge after the interrupt drops
		repeat (2) @(negedge clock_i);
	endtask

	task automatic t_attach;
		@(posedge clock_i);
		st_a <= 7'h2A;
		st_b <= 7'h15;
		att_a <= 1'b1;
		dp <= 1'b1;
		wait_int();
		`CHK({pa, pb}, 16'hAA15)
		@(posedge clock_i);
		att_b <= 1'b1;
		wait_int();
		`CHK({pb, sbu_en, aux_sel}, 10'h257)
		$display("test attach done");
	endtask

	task automatic t_gate;
		@(posedge clock_i);
		nrst_i <= 1'b0;
		cfg <= 8'h07;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		repeat (100) if (cfg_done !== 1'b1) @(negedge clock_i);
		repeat (30) @(negedge clock_i);
		`CHK({link.companion_reset_n, soc_en}, 2'b01)
		chk_pdo(1'b1);
		@(posedge clock_i);
		ec_done <= 1'b1;
		// clock enable low freezes the release as well
		ce_i <= 1'b0;
		repeat (3) @(negedge clock_i);
		`CHK(link.companion_reset_n, 1'b0)
		@(posedge clock_i);
		ce_i <= 1'b1;
		repeat (3) @(negedge clock_i);
		`CHK(link.companion_reset_n, 1'b1)
		$display("test gate done");
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_boot();
		t_fetch();
		t_attach();
		t_gate();
		summarize();
	end

	// the whole run needs about 4300 cycles
	initial begin
		repeat (20000) @(posedge clock_i);
		miscompares++;
		summarize();
	end
endmodule

`default_nettype wire
